/* gpr_pick.sv */
`timescale 1ns/1ns
// reads one byte or one pair out of the banked register snapshot
module gpr_pick
  import operand_addr_pkg::*;
#(
  parameter int NB = 1
) (
  input  wire logic [GPR_BITS-1:0] gpr,
  input  wire logic [4:0]          idx,
  output logic      [8*NB-1:0]     data
);

  logic [7:0] base_bit;

  // pairs are always picked at an even index, so the slice never runs off the top
  assign base_bit = {idx, 3'b000};
  assign data     = gpr[base_bit +: 8*NB];

endmodule

/* operand_addr_pkg.sv */
package operand_addr_pkg;

  // special opcodes recognised directly from the opcode byte
  localparam logic [7:0]  OPC_PUSH_PAIR3   = 8'hB5;
  localparam logic [7:0]  OPC_LOAD_A_PAIR3 = 8'h85;

  // byte register codes within a bank
  localparam logic [2:0]  REG_X = 3'h0;
  localparam logic [2:0]  REG_A = 3'h1;
  localparam logic [2:0]  REG_C = 3'h2;
  localparam logic [2:0]  REG_B = 3'h3;

  // register pair codes within a bank
  localparam logic [1:0]  PAIR_AX = 2'h0;
  localparam logic [1:0]  PAIR_DE = 2'h2;
  localparam logic [1:0]  PAIR_HL = 2'h3;

  // opcode field positions
  localparam int          REG_FIELD_LSB  = 0;
  localparam int          PAIR_FIELD_LSB = 1;

  // register file geometry: four banks of eight bytes
  localparam int          GPR_BITS = 256;

  // short direct window
  localparam logic [6:0]  SADDR_UPPER   = 7'h7F;
  localparam logic [7:0]  SADDR_WRAP_LO = 8'h20;

  // special register page and the hole that it does not reach
  localparam logic [7:0]  SFR_PAGE   = 8'hFF;
  localparam logic [7:0]  SFR_GAP_LO = 8'hD0;
  localparam logic [7:0]  SFR_GAP_HI = 8'hDF;

  // internal high-speed ram bounds for stack accesses
  localparam logic [15:0] HRAM_LO = 16'hFE20;
  localparam logic [15:0] HRAM_HI = 16'hFEFF;

  // reset values
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [4:0]  IDX_RST  = 5'h00;

  typedef enum logic [4:0] {
    OC_NONE       = 5'h00,
    OC_BYTE_MUL   = 5'h01,
    OC_WORD_DIV   = 5'h02,
    OC_DEC_ADJ    = 5'h03,
    OC_NIB_ROT    = 5'h04,
    OC_REG8       = 5'h05,
    OC_REG16      = 5'h06,
    OC_DIRECT     = 5'h07,
    OC_SADDR      = 5'h08,
    OC_SADDRP     = 5'h09,
    OC_SFR        = 5'h0A,
    OC_SFRP       = 5'h0B,
    OC_IND_DE     = 5'h0C,
    OC_IND_HL     = 5'h0D,
    OC_BASED      = 5'h0E,
    OC_BASED_B    = 5'h0F,
    OC_BASED_C    = 5'h10,
    OC_PUSH       = 5'h11,
    OC_POP        = 5'h12,
    OC_CALL       = 5'h13,
    OC_RET        = 5'h14,
    OC_INTR       = 5'h15
  } op_class_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALC = 2'b01,
    ST_DONE = 2'b11
  } state_t;

endpackage

/* operand_address_generator.sv */
`timescale 1ns/1ns
// Functional notes
// - multiply implicitly takes A as multiplicand and AX as product destination
// - word divide implicitly uses AX as dividend source and quotient destination
// - decimal adjust implicitly uses A as source and destination
// - nibble rotate implicitly uses A as the digit holder
// - multiply forms 16-bit product of A and X, stored into AX
// - register selected by both bank select bits joined with the code field
// - byte register comes from a 3-bit opcode field, eight per bank
// - codes 0..7 map X,A,C,B,E,D,L,H; pairs 0..3 map AX,BC,DE,HL
// - direct mode takes 16-bit address, low byte first then high
// - short direct reaches only the 256-byte window from one operand byte
// - bit 8 clear for operand 20H..FFH, set for 00H..1FH
// - short direct pair operand must be at an even address
// - special register address is page base plus byte, gap excluded
// - special register pair operand must be at an even address
// - register indirect uses whole DE or HL of the active bank
// - based mode adds zero-extended displacement to HL, carry dropped
// - based indexed adds zero-extended B or C to HL, carry dropped
// - stack addressing via stack pointer for push, pop, call, return, interrupt
// - stack accesses must stay inside internal high-speed ram; only the first byte's address is checked for a fault
// - opcode B5H decodes as push of the DE pair
// - opcode 85H decodes as load A from memory at DE
module operand_address_generator
  import operand_addr_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  input  wire logic                instr_valid,
  input  wire logic [4:0]          op_class,
  input  wire logic [7:0]          opcode,
  input  wire logic [7:0]          operand_lo,
  input  wire logic [7:0]          operand_hi,
  input  wire logic                bank_select_low,
  input  wire logic                bank_select_high,
  input  wire logic [15:0]         stack_ptr,
  input  wire logic [GPR_BITS-1:0] gpr_bytes,
  output logic                     instr_ready,
  output logic                     result_valid,
  output logic                     src_used,
  output logic [4:0]               src_idx,
  output logic                     dst_used,
  output logic [4:0]               dst_idx,
  output logic                     pair_op,
  output logic                     mem_used,
  output logic [15:0]              mem_addr,
  output logic                     stack_used,
  output logic [15:0]              stack_addr,
  output logic                     product_valid,
  output logic [15:0]              product,
  output logic                     addr_fault
);

  state_t          state_reg;
  state_t          state_next;

  op_class_t       class_reg;
  logic [7:0]      opcode_reg;
  logic [7:0]      op_lo_reg;
  logic [7:0]      op_hi_reg;
  logic [1:0]      bank_reg;
  logic [15:0]     sp_reg;
  logic [GPR_BITS-1:0] gpr_reg;

  logic            take;

  op_class_t       eff_class;
  logic [1:0]      eff_pair;
  logic [2:0]      field_reg8;
  logic [1:0]      field_pair;

  logic [4:0]      idx_a;
  logic [4:0]      idx_x;
  logic [4:0]      idx_b;
  logic [4:0]      idx_c;
  logic [4:0]      idx_ax;
  logic [4:0]      idx_hl;
  logic [4:0]      idx_ind;
  logic [4:0]      idx_r8;
  logic [4:0]      idx_rp;

  logic [7:0]      val_a;
  logic [7:0]      val_x;
  logic [7:0]      val_b;
  logic [7:0]      val_c;
  logic [15:0]     val_hl;
  logic [15:0]     val_ind;

  logic [15:0]     saddr_ea;
  logic [15:0]     sfr_ea;
  logic [15:0]     sp_dec;

  logic            src_used_next;
  logic [4:0]      src_idx_next;
  logic            dst_used_next;
  logic [4:0]      dst_idx_next;
  logic            pair_op_next;
  logic            mem_used_next;
  logic [15:0]     mem_addr_next;
  logic            stack_used_next;
  logic [15:0]     stack_addr_next;
  logic            product_valid_next;
  logic [15:0]     product_next;
  logic            addr_fault_next;

  assign take = instr_valid && instr_ready;

  // sequencing: take, compute, present for one cycle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          state_next = ST_CALC;
        end
      end
      ST_CALC: begin
        state_next = ST_DONE;
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      instr_ready  <= 1'b1;
      result_valid <= 1'b0;
    end else begin
      instr_ready  <= (state_next == ST_IDLE);
      result_valid <= (state_reg == ST_CALC);
    end
  end

  // bank bits and register contents are frozen at the take, so a bank
  // switch by a later instruction cannot leak into this operand
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      class_reg  <= OC_NONE;
      opcode_reg <= 8'h00;
      op_lo_reg  <= 8'h00;
      op_hi_reg  <= 8'h00;
      bank_reg   <= 2'h0;
      sp_reg     <= ADDR_RST;
      gpr_reg    <= '0;
    end else if (take) begin
      class_reg  <= op_class_t'(op_class);
      opcode_reg <= opcode;
      op_lo_reg  <= operand_lo;
      op_hi_reg  <= operand_hi;
      bank_reg   <= {bank_select_high, bank_select_low};
      sp_reg     <= stack_ptr;
      gpr_reg    <= gpr_bytes;
    end
  end

  // two opcodes are known outright and override the predecoded class
  always_comb begin
    eff_class = class_reg;
    eff_pair  = PAIR_HL;
    if (opcode_reg == OPC_PUSH_PAIR3) begin
      eff_class = OC_PUSH;
      eff_pair  = PAIR_DE;
    end else if (opcode_reg == OPC_LOAD_A_PAIR3) begin
      eff_class = OC_IND_DE;
      eff_pair  = PAIR_DE;
    end else if (class_reg == OC_IND_DE) begin
      eff_pair  = PAIR_DE;
    end
  end

  assign field_reg8 = opcode_reg[REG_FIELD_LSB +: 3];
  assign field_pair = opcode_reg[PAIR_FIELD_LSB +: 2];

  // register index is bank bits on top of the code, pairs at even bytes
  assign idx_a   = {bank_reg, REG_A};
  assign idx_x   = {bank_reg, REG_X};
  assign idx_b   = {bank_reg, REG_B};
  assign idx_c   = {bank_reg, REG_C};
  assign idx_ax  = {bank_reg, PAIR_AX, 1'b0};
  assign idx_hl  = {bank_reg, PAIR_HL, 1'b0};
  assign idx_ind = {bank_reg, eff_pair, 1'b0};
  assign idx_r8  = {bank_reg, field_reg8};
  assign idx_rp  = {bank_reg, field_pair, 1'b0};

  gpr_pick #(.NB(1)) pick_a (
    .gpr  (gpr_reg),
    .idx  (idx_a),
    .data (val_a)
  );

  gpr_pick #(.NB(1)) pick_x (
    .gpr  (gpr_reg),
    .idx  (idx_x),
    .data (val_x)
  );

  gpr_pick #(.NB(1)) pick_b (
    .gpr  (gpr_reg),
    .idx  (idx_b),
    .data (val_b)
  );

  gpr_pick #(.NB(1)) pick_c (
    .gpr  (gpr_reg),
    .idx  (idx_c),
    .data (val_c)
  );

  gpr_pick #(.NB(2)) pick_hl (
    .gpr  (gpr_reg),
    .idx  (idx_hl),
    .data (val_hl)
  );

  gpr_pick #(.NB(2)) pick_ind (
    .gpr  (gpr_reg),
    .idx  (idx_ind),
    .data (val_ind)
  );

  // operand 00H..1FH folds up into the sfr block above the ram
  assign saddr_ea = {SADDR_UPPER, (op_lo_reg < SADDR_WRAP_LO), op_lo_reg};
  assign sfr_ea   = {SFR_PAGE, op_lo_reg};
  assign sp_dec   = sp_reg - 16'h0001;

  always_comb begin
    src_used_next      = 1'b0;
    src_idx_next       = IDX_RST;
    dst_used_next      = 1'b0;
    dst_idx_next       = IDX_RST;
    pair_op_next       = 1'b0;
    mem_used_next      = 1'b0;
    mem_addr_next      = ADDR_RST;
    stack_used_next    = 1'b0;
    stack_addr_next    = ADDR_RST;
    product_valid_next = 1'b0;
    product_next       = 16'h0000;
    addr_fault_next    = 1'b0;
    case (eff_class)
      OC_BYTE_MUL: begin
        src_used_next      = 1'b1;
        src_idx_next       = idx_a;
        dst_used_next      = 1'b1;
        dst_idx_next       = idx_ax;
        product_valid_next = 1'b1;
        product_next       = {8'h00, val_a} * {8'h00, val_x};
      end
      OC_WORD_DIV: begin
        pair_op_next  = 1'b1;
        src_used_next = 1'b1;
        src_idx_next  = idx_ax;
        dst_used_next = 1'b1;
        dst_idx_next  = idx_ax;
      end
      OC_DEC_ADJ: begin
        src_used_next = 1'b1;
        src_idx_next  = idx_a;
        dst_used_next = 1'b1;
        dst_idx_next  = idx_a;
      end
      OC_NIB_ROT: begin
        src_used_next = 1'b1;
        src_idx_next  = idx_a;
        dst_used_next = 1'b1;
        dst_idx_next  = idx_a;
      end
      OC_REG8: begin
        src_used_next = 1'b1;
        src_idx_next  = idx_r8;
        dst_used_next = 1'b1;
        dst_idx_next  = idx_r8;
      end
      OC_REG16: begin
        pair_op_next  = 1'b1;
        src_used_next = 1'b1;
        src_idx_next  = idx_rp;
        dst_used_next = 1'b1;
        dst_idx_next  = idx_rp;
      end
      OC_DIRECT: begin
        mem_used_next = 1'b1;
        mem_addr_next = {op_hi_reg, op_lo_reg};
      end
      OC_SADDR: begin
        mem_used_next = 1'b1;
        mem_addr_next = saddr_ea;
      end
      OC_SADDRP: begin
        pair_op_next    = 1'b1;
        mem_used_next   = 1'b1;
        mem_addr_next   = saddr_ea;
        addr_fault_next = op_lo_reg[0];
      end
      OC_SFR: begin
        mem_used_next   = 1'b1;
        mem_addr_next   = sfr_ea;
        addr_fault_next = (op_lo_reg >= SFR_GAP_LO) && (op_lo_reg <= SFR_GAP_HI);
      end
      OC_SFRP: begin
        pair_op_next    = 1'b1;
        mem_used_next   = 1'b1;
        mem_addr_next   = sfr_ea;
        // which sfrs take word access is not known here; only parity and gap
        addr_fault_next = op_lo_reg[0] ||
                          ((op_lo_reg >= SFR_GAP_LO) && (op_lo_reg <= SFR_GAP_HI));
      end
      OC_IND_DE, OC_IND_HL: begin
        mem_used_next = 1'b1;
        mem_addr_next = val_ind;
        if (opcode_reg == OPC_LOAD_A_PAIR3) begin
          dst_used_next = 1'b1;
          dst_idx_next  = idx_a;
        end
      end
      OC_BASED: begin
        mem_used_next = 1'b1;
        mem_addr_next = val_hl + {8'h00, op_lo_reg};
      end
      OC_BASED_B: begin
        mem_used_next = 1'b1;
        mem_addr_next = val_hl + {8'h00, val_b};
      end
      OC_BASED_C: begin
        mem_used_next = 1'b1;
        mem_addr_next = val_hl + {8'h00, val_c};
      end
      OC_PUSH, OC_CALL, OC_INTR: begin
        // first byte goes below the current top of stack
        stack_used_next = 1'b1;
        stack_addr_next = sp_dec;
        addr_fault_next = (sp_dec < HRAM_LO) || (sp_dec > HRAM_HI);
        if (eff_class == OC_PUSH) begin
          pair_op_next  = 1'b1;
          src_used_next = 1'b1;
          src_idx_next  = idx_ind;
        end
      end
      OC_POP, OC_RET: begin
        stack_used_next = 1'b1;
        stack_addr_next = sp_reg;
        addr_fault_next = (sp_reg < HRAM_LO) || (sp_reg > HRAM_HI);
      end
      default: begin
        src_used_next = 1'b0;
      end
    endcase
  end

  // results are loaded in the compute state and held until the next one
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_used      <= 1'b0;
      src_idx       <= IDX_RST;
      dst_used      <= 1'b0;
      dst_idx       <= IDX_RST;
      pair_op       <= 1'b0;
      mem_used      <= 1'b0;
      mem_addr      <= ADDR_RST;
      stack_used    <= 1'b0;
      stack_addr    <= ADDR_RST;
      product_valid <= 1'b0;
      product       <= 16'h0000;
      addr_fault    <= 1'b0;
    end else if (state_reg == ST_CALC) begin
      src_used      <= src_used_next;
      src_idx       <= src_idx_next;
      dst_used      <= dst_used_next;
      dst_idx       <= dst_idx_next;
      pair_op       <= pair_op_next;
      mem_used      <= mem_used_next;
      mem_addr      <= mem_addr_next;
      stack_used    <= stack_used_next;
      stack_addr    <= stack_addr_next;
      product_valid <= product_valid_next;
      product       <= product_next;
      addr_fault    <= addr_fault_next;
    end
  end

endmodule

/* operand_checker_asserts.sv */
`timescale 1ns/1ns
module operand_checker
  import operand_addr_pkg::*;
(
  input wire logic                sys_clk,
  input wire logic                sys_rst,
  input wire logic                instr_valid,
  input wire logic [4:0]          op_class,
  input wire logic [7:0]          opcode,
  input wire logic [7:0]          operand_lo,
  input wire logic [7:0]          operand_hi,
  input wire logic                bank_select_low,
  input wire logic                bank_select_high,
  input wire logic [15:0]         stack_ptr,
  input wire logic [GPR_BITS-1:0] gpr_bytes,
  input wire logic                instr_ready,
  input wire logic                result_valid,
  input wire logic                src_used,
  input wire logic [4:0]          src_idx,
  input wire logic                dst_used,
  input wire logic [4:0]          dst_idx,
  input wire logic                pair_op,
  input wire logic                mem_used,
  input wire logic [15:0]         mem_addr,
  input wire logic                stack_used,
  input wire logic [15:0]         stack_addr,
  input wire logic                product_valid,
  input wire logic [15:0]         product,
  input wire logic                addr_fault
);
  // held from the take edge, since the inputs move on before the result shows
  logic [4:0]          k_cls;
  logic [7:0]          k_opc, k_lo, k_hi;
  logic [1:0]          k_bk;
  logic [15:0]         k_sp, hl, de;
  logic [GPR_BITS-1:0] k_gpr;
  logic                fin;
  assign fin = result_valid && k_opc != OPC_PUSH_PAIR3 && k_opc != OPC_LOAD_A_PAIR3;
  assign hl = {k_gpr[{k_bk, 3'h7}*8 +: 8], k_gpr[{k_bk, 3'h6}*8 +: 8]};
  assign de = {k_gpr[{k_bk, 3'h5}*8 +: 8], k_gpr[{k_bk, 3'h4}*8 +: 8]};
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {k_cls, k_opc, k_lo, k_hi, k_bk, k_sp, k_gpr} <= '0;
    end else if (instr_valid && instr_ready) begin
      {k_cls, k_opc, k_lo, k_hi} <= {op_class, opcode, operand_lo, operand_hi};
      {k_bk, k_sp, k_gpr} <= {bank_select_high, bank_select_low, stack_ptr, gpr_bytes};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_latency;
    instr_valid && instr_ready |=> (!instr_ready && !result_valid)
      ##1 (result_valid && !instr_ready) ##1 (instr_ready && !result_valid);
  endproperty
  a_latency: assert property (p_latency) else $error("result timing wrong");
  property p_reg8; fin && k_cls == OC_REG8 |-> src_idx == {k_bk, k_opc[2:0]}; endproperty
  a_reg8: assert property (p_reg8) else $error("byte register index wrong");
  property p_mul;
    fin && k_cls == OC_BYTE_MUL |-> product_valid
      && product == {8'h00, k_gpr[{k_bk, REG_A}*8 +: 8]} * {8'h00, k_gpr[{k_bk, REG_X}*8 +: 8]};
  endproperty
  a_mul: assert property (p_mul) else $error("product wrong");
  property p_saddr; fin && k_cls == OC_SADDR |-> mem_addr == {7'h7F, k_lo < 8'h20, k_lo}; endproperty
  a_saddr: assert property (p_saddr) else $error("short direct address wrong");
  property p_sfr;
    fin && k_cls == OC_SFR |-> mem_addr == {8'hFF, k_lo}
      && addr_fault == (k_lo >= 8'hD0 && k_lo <= 8'hDF);
  endproperty
  a_sfr: assert property (p_sfr) else $error("special register address wrong");
  property p_based; fin && k_cls == OC_BASED |-> mem_addr == hl + {8'h00, k_lo}; endproperty
  a_based: assert property (p_based) else $error("based address wrong");
  property p_push;
    result_valid && k_opc == OPC_PUSH_PAIR3 |-> stack_used && stack_addr == k_sp - 16'h0001;
  endproperty
  a_push: assert property (p_push) else $error("push decode wrong");
  property p_load; result_valid && k_opc == OPC_LOAD_A_PAIR3 |-> mem_addr == de; endproperty
  a_load: assert property (p_load) else $error("indirect load decode wrong");
  c_mul: cover property (fin && k_cls == OC_BYTE_MUL);
  c_push: cover property (result_valid && k_opc == OPC_PUSH_PAIR3);
  c_fault: cover property (result_valid && addr_fault);
endmodule

/* regfile_model.sv */
`timescale 1ns/1ns
module regfile_model
  import operand_addr_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                wr_en,
  input  wire logic [4:0]          wr_idx,
  input  wire logic [7:0]          wr_data,
  output logic      [GPR_BITS-1:0] gpr_bytes
);
  // byte index is {bank, code}; pairs are two neighbouring bytes, low one even
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      gpr_bytes[wr_idx*8 +: 8] <= wr_data;
    end
  end
endmodule

/* tb.sv */
`timescale 1ns/1ns
module tb;
  import operand_addr_pkg::*;
  logic                sys_clk, sys_rst, instr_valid, bank_select_low, bank_select_high;
  logic [4:0]          op_class, src_idx, dst_idx, wr_idx;
  logic [7:0]          opcode, operand_lo, operand_hi, wr_data;
  logic [15:0]         stack_ptr, mem_addr, stack_addr, product, lfsr;
  logic [GPR_BITS-1:0] gpr_bytes;
  logic                instr_ready, result_valid, src_used, dst_used, pair_op, mem_used;
  logic                stack_used, product_valid, addr_fault, wr_en;
  logic [7:0]          shadow [32];
  logic [7:0]          corner [8] = '{8'h00, 8'h1F, 8'h20, 8'hFF, 8'hD0, 8'hDF, 8'hCF, 8'hE1};
  int                  bad_count, total_checks, cycles;

  operand_address_generator i_operand_address_generator (.*);
  regfile_model i_regfile_model (.*);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // the sweep needs about 9100 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      finish_test();
    end
  end

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] gb(input logic [1:0] b, input logic [2:0] c);
    return shadow[{b, c}];
  endfunction
  function automatic logic [5:0] exp_flags(input logic [4:0] c, input logic [7:0] o);
    // order: src, dst, pair, mem, stack, product
    if (o == OPC_PUSH_PAIR3) return 6'b101010;
    if (o == OPC_LOAD_A_PAIR3) return 6'b010100;
    case (c)
      OC_BYTE_MUL: return 6'b110001;
      OC_WORD_DIV, OC_REG16: return 6'b111000;
      OC_DEC_ADJ, OC_NIB_ROT, OC_REG8: return 6'b110000;
      OC_SADDRP, OC_SFRP: return 6'b001100;
      OC_DIRECT, OC_SADDR, OC_SFR, OC_IND_DE, OC_IND_HL: return 6'b000100;
      OC_BASED, OC_BASED_B, OC_BASED_C: return 6'b000100;
      OC_PUSH: return 6'b101010;
      OC_POP, OC_RET, OC_CALL, OC_INTR: return 6'b000010;
      default: return 6'b000000;
    endcase
  endfunction
  task automatic roll(output logic [7:0] v);
    lfsr = lfsr_step(lfsr);
    v = lfsr[7:0];
  endtask
  task automatic c16(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic c1(input string nm, input logic e, input logic g);
    c16(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic fill();
    logic [7:0] v;
    for (int i = 0; i < 32; i++) begin
      roll(v);
      @(posedge sys_clk);
      wr_en <= 1'b1;
      wr_idx <= 5'(i);
      wr_data <= v;
      shadow[i] = v;
    end
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task automatic run_op(input logic [4:0] cls, input logic [7:0] opc, input logic [7:0] lo);
    logic [7:0]  hi, r;
    logic [1:0]  b;
    logic [15:0] sp, sa, hl, de;
    logic [5:0]  seen;
    int          n;
    roll(hi);
    roll(r);
    b = r[1:0];
    sp = {r[2] ? 8'hFE : hi, r ^ hi};
    @(posedge sys_clk);
    op_class <= cls;
    opcode <= opc;
    operand_lo <= lo;
    operand_hi <= hi;
    {bank_select_high, bank_select_low} <= b;
    stack_ptr <= sp;
    instr_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (instr_ready !== 1'b1 && n < 20);
    instr_valid <= 1'b0;
    while (result_valid !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    c1("result_valid", 1'b1, result_valid);
    seen = {src_used, dst_used, pair_op, mem_used, stack_used, product_valid};
    c16("used_flags", {10'h000, exp_flags(cls, opc)}, {10'h000, seen});
    hl = {gb(b, 3'h7), gb(b, 3'h6)};
    de = {gb(b, 3'h5), gb(b, 3'h4)};
    sa = (cls == OC_POP || cls == OC_RET) ? sp : sp - 16'h0001;
    if (opc == OPC_PUSH_PAIR3) begin
      c16("push_src", {b, 3'h4}, src_idx);
      c16("push_sp", sp - 16'h0001, stack_addr);
    end else if (opc == OPC_LOAD_A_PAIR3) begin
      c16("load_addr", de, mem_addr);
      c16("load_dst", {b, 3'h1}, dst_idx);
    end else begin
      case (cls)
        OC_BYTE_MUL: begin
          c16("product", {8'h00, gb(b, 3'h1)} * {8'h00, gb(b, 3'h0)}, product);
          c16("mul_idx", {b, 3'h1, b, 3'h0}, {src_idx, dst_idx});
        end
        OC_WORD_DIV: c16("div_idx", {b, 3'h0, b, 3'h0}, {src_idx, dst_idx});
        OC_DEC_ADJ: c16("adj_idx", {b, 3'h1, b, 3'h1}, {src_idx, dst_idx});
        OC_NIB_ROT: c16("rot_idx", {b, 3'h1, b, 3'h1}, {src_idx, dst_idx});
        OC_REG8: c16("reg8", {b, opc[2:0]}, src_idx);
        OC_REG16: c16("reg16", {b, opc[2:1], 1'b0}, src_idx);
        OC_DIRECT: c16("direct", {hi, lo}, mem_addr);
        OC_SADDR, OC_SADDRP: begin
          c16("saddr", {7'h7F, lo < 8'h20, lo}, mem_addr);
          c1("saddr_fault", cls == OC_SADDRP && lo[0], addr_fault);
        end
        OC_SFR, OC_SFRP: begin
          c16("sfr", {8'hFF, lo}, mem_addr);
          c1("sfr_fault", lo[7:4] == 4'hD || (cls == OC_SFRP && lo[0]), addr_fault);
        end
        OC_IND_DE: c16("ind_de", de, mem_addr);
        OC_IND_HL: c16("ind_hl", hl, mem_addr);
        OC_BASED: c16("based", hl + {8'h00, lo}, mem_addr);
        OC_BASED_B: c16("based_b", hl + {8'h00, gb(b, 3'h3)}, mem_addr);
        OC_BASED_C: c16("based_c", hl + {8'h00, gb(b, 3'h2)}, mem_addr);
        OC_PUSH, OC_POP, OC_CALL, OC_RET, OC_INTR: begin
          c16("stack", sa, stack_addr);
          c1("stack_fault", sa < 16'hFE20 || sa > 16'hFEFF, addr_fault);
        end
        default: ;
      endcase
    end
  endtask

  initial begin
    logic [7:0] v;
    lfsr = 16'h0045;
    sys_rst = 1'b1;
    {instr_valid, op_class, opcode, operand_lo, operand_hi} = '0;
    {bank_select_low, bank_select_high, stack_ptr, wr_en, wr_idx, wr_data} = '0;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    c1("ready_after_reset", 1'b1, instr_ready);
    // opcodes keep bit 7 clear so the two fixed opcodes never override a class by chance
    for (int c = 1; c <= 21; c++) begin
      for (int k = 0; k < 12; k++) begin
        roll(v);
        fill();
        run_op(5'(c), v & 8'h7F, k < 8 ? corner[k] : v);
      end
      $display("class %0d done, mismatches %0d", c, bad_count);
    end
    run_op(OC_REG8, OPC_PUSH_PAIR3, 8'h00);
    run_op(OC_SADDR, OPC_LOAD_A_PAIR3, 8'h10);
    run_op(OC_NONE, 8'h00, 8'h00);
    $display("fixed opcodes done, mismatches %0d", bad_count);
    finish_test();
  end
endmodule

bind operand_address_generator operand_checker i_operand_checker (.*);
